/* rtl/bpc_boost_ctrl.sv */
// Boost PWM control, configuration and status registers behind I2C
//
// Contract
// - Power-up loads all control registers with defaults; device starts shut down.
// - Config D7 picks half (1) or full (0) boost current scale.
// - Config D6: clear input keeps registers (0) or restores defaults (1).
// - Config D5 staggers port PWM outputs when 1, in phase when 0.
// - Config D4 reads back 1 during hold-off, else 0.
// - Config D3 reads back 1 during fade-off, else 0.
// - Config D2 reads back 1 during ramp-up, else 0.
// - Config D1 lets the clear input start the device from shutdown.
// - Config D0 selects shutdown (0) or run (1); default 0.
// - All five port control registers reset to high impedance.
// - Config, fade-off and fade-on registers reset to zero.
// - Port current reset: ports 0,1 full, 2-4 half; ceiling maximal.
// - Both duty registers reset to zero; status resets with standby set.
// - Boost PWM uses a 10-bit counter stepped at 125 kHz.
// - Duty is setting over 1024; zero keeps converter off.
// - Upper duty register holds duty bits 9 to 2.
// - Lower duty register holds bits 1 and 0; upper six read zero.
// - Status D0 set forces standby; reserved D7-D5 read zero.
// - Status D1 flags boost output overvoltage.
// - Status D2 flags thermal shutdown.
// - Status D3 flags current limit.
// - Reading status clears latched faults; faults still present set again.
// - Converter off when run is 0, standby 1, or duty zero.
`timescale 1ns/1ps
module bpc_boost_ctrl (
    input  wire logic           clock_in,
    input  wire logic           nrst_in,
    input  wire logic           scl_in,
    input  wire logic           sda_in,
    input  wire logic           clear_n_in,
    input  wire logic [1:0]     addr_sel_in,
    input  wire logic           ovp_in,
    input  wire logic           thermal_in,
    input  wire logic           ilimit_in,
    input  wire logic           schottky_open_in,
    input  wire logic           holdoff_in,
    input  wire logic           fade_off_busy_in,
    input  wire logic           ramp_up_busy_in,
    output logic                sda_out,
    output logic                sda_oe_out,
    output bpc_pkg::bpc_ports_t port_ctrl_out,
    output bpc_pkg::bpc_cfg_s   cfg_out,
    output bpc_pkg::bpc_byte_t  fade_off_out,
    output bpc_pkg::bpc_byte_t  fade_on_out,
    output bpc_pkg::bpc_byte_t  cur_scale_out,
    output bpc_pkg::bpc_byte_t  cur_ceil_out,
    output logic                standby_out,
    output logic                boost_en_out
);
    import bpc_pkg::*;

    localparam bpc_state_s ST_RST = init_state();

    bpc_state_s      q;
    bpc_state_s      n;
    logic [SY_W-1:0] f;
    logic [SY_W-1:0] p;
    logic            scl_rise, scl_fall, start_c, stop_c;
    logic            clr_lvl, clr_evt, wr_en, rd_load, stat_rd;
    logic            tick, active;
    bpc_byte_t       wr_addr, wr_data;
    bpc_duty_t       duty;
    bpc_cfg_s        cfg_rd;

    // Read-back view of one register
    function automatic bpc_byte_t reg_read(input bpc_state_s s,
                                           input bpc_byte_t  a,
                                           input bpc_cfg_s   c);
        bpc_byte_t v;
        v = POR_ZERO;
        case (a)
            REG_PORT0, REG_PORT1, REG_PORT2, REG_PORT3, REG_PORT4:
                v = s.port[a[2:0]];
            REG_GRP_ALL, REG_GRP_LO, REG_GRP_HI: v = s.port[0];
            REG_CFG:      v = c;
            REG_FADE_OFF: v = s.fade_off;
            REG_FADE_ON:  v = s.fade_on;
            REG_CUR_SCL:  v = s.cur_scl;
            REG_CUR_CEIL: v = s.cur_ceil;
            REG_DUTY_HI:  v = s.duty_hi;
            REG_DUTY_LO:  v = s.duty_lo & DUTY_LO_MASK;
            REG_STATUS:   v = s.stat;
            default:      v = POR_ZERO;
        endcase
        return v;
    endfunction : reg_read

    // Auto-increment order; port, group and current-ceiling ends wrap to the config register; input port, duty-low and status hold
    function automatic bpc_byte_t next_ptr(input bpc_byte_t a);
        bpc_byte_t v;
        v = a + 8'h01;
        case (a)
            REG_PORT4, REG_GRP_ALL, REG_GRP_LO, REG_GRP_HI, REG_CUR_CEIL:
                v = REG_CFG;
            REG_PORT_IN, REG_DUTY_LO, REG_STATUS: v = a;
            default: v = a + 8'h01;
        endcase
        return v;
    endfunction : next_ptr

    // Next-state logic for the whole block
    always_comb begin
        n       = q;
        wr_en   = 1'b0;
        rd_load = 1'b0;
        stat_rd = 1'b0;
        wr_addr = POR_ZERO;
        wr_data = POR_ZERO;
        // Three-stage sampling; a lane moves once stages two and three agree
        n.s1 = {addr_sel_in, schottky_open_in, ilimit_in, thermal_in,
                ovp_in, clear_n_in, sda_in, scl_in};
        n.s2 = q.s1;
        n.s3 = q.s2;
        n.filt = (~(q.s2 ^ q.s3) & q.s2) | ((q.s2 ^ q.s3) & q.filt);
        f = n.filt;
        p = q.filt;
        scl_rise = ~p[SY_SCL] & f[SY_SCL];
        scl_fall = p[SY_SCL] & ~f[SY_SCL];
        start_c  = p[SY_SCL] & f[SY_SCL] & p[SY_SDA] & ~f[SY_SDA];
        stop_c   = p[SY_SCL] & f[SY_SCL] & ~p[SY_SDA] & f[SY_SDA];
        clr_lvl  = ~f[SY_CLR];
        clr_evt  = clr_lvl & p[SY_CLR];
        // ramp status shown live, never stored
        cfg_rd            = q.cfg;
        cfg_rd.holdoff    = holdoff_in;
        cfg_rd.fading_off = fade_off_busy_in;
        cfg_rd.ramping_up = ramp_up_busy_in;

        tick  = (q.div == TICK_LAST);
        n.div = tick ? POR_ZERO : q.div + 8'h01;
        if (tick) n.pwm_cnt = q.pwm_cnt + 10'h001;
        duty   = {q.duty_hi, q.duty_lo[1:0]};
        active = q.cfg.run & ~q.stat.standby & (duty != 10'h000)
                 & ~q.filt[SY_OVP] & ~q.filt[SY_THM];
        n.boost_en = active & (q.pwm_cnt < duty);

        // Serial slave; the clear input also resets the interface
        if (clr_lvl) begin
            n.phase    = I2C_IDLE;
            n.ack_slot = 1'b0;
            n.sda_oe   = 1'b0;
        end else if (start_c) begin
            // SCL fall after START is no bit: it closes a dummy ack slot
            n.phase    = I2C_ADDR;
            n.bit_cnt  = 3'h0;
            n.ack_slot = 1'b1;
            n.sda_oe   = 1'b0;
        end else if (stop_c) begin
            n.phase    = I2C_IDLE;
            n.ack_slot = 1'b0;
            n.sda_oe   = 1'b0;
        end else if (q.phase != I2C_IDLE && scl_rise) begin
            if (!q.ack_slot) n.shreg = {q.shreg[6:0], f[SY_SDA]};
            else n.rd_nack = f[SY_SDA];
        end else if (q.phase != I2C_IDLE && scl_fall) begin
            if (q.ack_slot) begin
                n.ack_slot = 1'b0;
                n.sda_oe   = 1'b0;
                n.bit_cnt  = 3'h0;
                if (q.phase == I2C_RD && q.rd_nack) begin
                    n.phase = I2C_IDLE;
                end else if (q.phase == I2C_RD) begin
                    // Capture before the fault flags are cleared
                    rd_load  = 1'b1;
                    n.tx     = reg_read(q, q.ptr, cfg_rd);
                    n.sda_oe = ~n.tx[7];
                    n.ptr    = next_ptr(q.ptr);
                    stat_rd  = (q.ptr == REG_STATUS);
                end
            end else if (q.bit_cnt != BIT_LAST) begin
                n.bit_cnt = q.bit_cnt + 3'h1;
                if (q.phase == I2C_RD) begin
                    n.tx     = {q.tx[6:0], 1'b0};
                    n.sda_oe = ~q.tx[6];
                end
            end else begin
                n.ack_slot = 1'b1;
                n.sda_oe   = 1'b1;
                unique case (q.phase)
                    I2C_ADDR: begin
                        if (q.shreg[7:1] == {I2C_ADDR_HI, f[SY_AS0+:2]}) begin
                            n.phase   = q.shreg[0] ? I2C_RD : I2C_PTR;
                            n.rd_nack = 1'b0;
                        end else begin
                            n.phase    = I2C_IDLE;
                            n.ack_slot = 1'b0;
                            n.sda_oe   = 1'b0;
                        end
                    end
                    I2C_PTR: begin
                        n.ptr   = q.shreg;
                        n.phase = I2C_WR;
                    end
                    I2C_WR: begin
                        wr_en   = 1'b1;
                        wr_addr = q.ptr;
                        wr_data = q.shreg;
                        n.ptr   = next_ptr(q.ptr);
                    end
                    // Master drives its own acknowledge after a read byte
                    I2C_RD: n.sda_oe = 1'b0;
                    default: begin
                        n.ack_slot = 1'b0;
                        n.sda_oe   = 1'b0;
                    end
                endcase
            end
        end

        // Register writes; unmapped offsets are acknowledged and dropped
        if (wr_en) begin
            case (wr_addr)
                REG_PORT0, REG_PORT1, REG_PORT2, REG_PORT3, REG_PORT4:
                    n.port[wr_addr[2:0]] = wr_data;
                REG_GRP_ALL: begin
                    for (int i = 0; i < NUM_PORTS; i++) n.port[i] = wr_data;
                end
                REG_GRP_LO: begin
                    n.port[0] = wr_data;
                    n.port[1] = wr_data;
                end
                REG_GRP_HI: begin
                    n.port[2] = wr_data;
                    n.port[3] = wr_data;
                    n.port[4] = wr_data;
                end
                // config write; status bits are not stored
                REG_CFG: begin
                    n.cfg            = bpc_cfg_s'(wr_data);
                    n.cfg.holdoff    = 1'b0;
                    n.cfg.fading_off = 1'b0;
                    n.cfg.ramping_up = 1'b0;
                end
                REG_FADE_OFF: n.fade_off = wr_data;
                REG_FADE_ON:  n.fade_on  = wr_data;
                REG_CUR_SCL:  n.cur_scl  = wr_data;
                REG_CUR_CEIL: n.cur_ceil = wr_data;
                REG_DUTY_HI:  n.duty_hi  = wr_data;
                // lower duty bits, reserved kept zero
                REG_DUTY_LO:  n.duty_lo  = wr_data & DUTY_LO_MASK;
                // standby bit is the only writable status bit
                REG_STATUS:   n.stat.standby = wr_data[0];
                default: ;
            endcase
        end

        if (clr_evt) begin
            if (q.cfg.por_on_clear) n = reg_por(n);
            if (q.cfg.reset_run) n.cfg.run = 1'b1;
        end
        // Overheating parks the converter and drops run mode
        if (f[SY_THM] & ~p[SY_THM]) begin
            n.stat.standby = 1'b1;
            n.cfg.run      = 1'b0;
        end
        // sticky faults; read clears, live fault wins
        n.stat.ovp      = (n.stat.ovp & ~stat_rd) | f[SY_OVP];
        n.stat.thermal  = (n.stat.thermal & ~stat_rd) | f[SY_THM];
        n.stat.ilimit   = (n.stat.ilimit & ~stat_rd) | f[SY_ILM];
        n.stat.schottky = (n.stat.schottky & ~stat_rd) | f[SY_SCH];
    end

    // state register, power-on values under reset
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) q <= ST_RST;
        else q <= n;
    end

    // Outputs straight from the state register; sda_out is tied low
    assign sda_out       = 1'b0;
    assign sda_oe_out    = q.sda_oe;
    assign port_ctrl_out = q.port;
    assign cfg_out       = q.cfg;
    assign fade_off_out  = q.fade_off;
    assign fade_on_out   = q.fade_on;
    assign cur_scale_out = q.cur_scl;
    assign cur_ceil_out  = q.cur_ceil;
    assign standby_out   = q.stat.standby;
    assign boost_en_out  = q.boost_en;

    // Checks beside the logic they guard
    property p_por;
        @(posedge clock_in) disable iff (!nrst_in)
        !$past(nrst_in) |-> !cfg_out.run && standby_out
            && port_ctrl_out == {NUM_PORTS{POR_PORT}};
    endproperty
    a_por: assert property (p_por) else $error("bad power-on state");
    property p_cur_por;
        @(posedge clock_in) disable iff (!nrst_in)
        !$past(nrst_in) |-> cur_scale_out == POR_CUR_SCL
            && cur_ceil_out == POR_CUR_CEIL && fade_on_out == POR_ZERO;
    endproperty
    a_cur_por: assert property (p_cur_por) else $error("bad cur reset");
    property p_half;
        @(posedge clock_in) disable iff (!nrst_in)
        wr_en && wr_addr == REG_CFG && !clr_evt
            |=> cfg_out.half_scale == $past(wr_data[7]);
    endproperty
    a_half: assert property (p_half) else $error("scale not taken");
    property p_clr_keep;
        @(posedge clock_in) disable iff (!nrst_in)
        clr_evt && !q.cfg.por_on_clear && !wr_en |=> $stable(port_ctrl_out);
    endproperty
    a_clr_keep: assert property (p_clr_keep) else $error("clear lost");
    property p_run_clr;
        @(posedge clock_in) disable iff (!nrst_in)
        clr_evt && q.cfg.reset_run && !f[SY_THM] |=> cfg_out.run;
    endproperty
    a_run_clr: assert property (p_run_clr) else $error("no reset run");
    property p_duty_wr;
        @(posedge clock_in) disable iff (!nrst_in)
        wr_en && wr_addr == REG_DUTY_HI && !clr_evt
            |=> duty[9:2] == $past(wr_data);
    endproperty
    a_duty_wr: assert property (p_duty_wr) else $error("duty hi");
    property p_lsb;
        @(posedge clock_in) disable iff (!nrst_in)
        rd_load && q.ptr == REG_DUTY_LO |=> q.tx[7:2] == 6'h00;
    endproperty
    a_lsb: assert property (p_lsb) else $error("lsb reserved set");
    property p_tick;
        @(posedge clock_in) disable iff (!nrst_in)
        tick |=> !tick [*8] ##0 q.pwm_cnt == $past(q.pwm_cnt, 8) + 10'h001;
    endproperty
    a_tick: assert property (p_tick) else $error("pwm step wrong");
    property p_off;
        @(posedge clock_in) disable iff (!nrst_in)
        (!cfg_out.run || standby_out || duty == 10'h000)
            |=> !boost_en_out;
    endproperty
    a_off: assert property (p_off) else $error("boost on in off");
    property p_on;
        @(posedge clock_in) disable iff (!nrst_in)
        active && q.pwm_cnt < duty |=> boost_en_out;
    endproperty
    a_on: assert property (p_on) else $error("boost not on");
    property p_ovp;
        @(posedge clock_in) disable iff (!nrst_in)
        f[SY_OVP] |=> q.stat.ovp;
    endproperty
    a_ovp: assert property (p_ovp) else $error("ovp flag lost");
    property p_fault_rd;
        @(posedge clock_in) disable iff (!nrst_in)
        stat_rd |=> q.stat.ilimit == q.filt[SY_ILM]
            && q.stat.ovp == q.filt[SY_OVP];
    endproperty
    a_fault_rd: assert property (p_fault_rd) else $error("no clear");
endmodule : bpc_boost_ctrl

/* rtl/bpc_pkg.sv */
// Package: constants, types and power-on values of the boost PWM block
package bpc_pkg;
    // Clock rates; the PWM tick divider follows from them
    localparam int unsigned CLK_HZ      = 25_000_000;
    localparam int unsigned PWM_CLK_HZ  = 125_000;
    localparam int unsigned TICK_CYCLES = CLK_HZ / PWM_CLK_HZ;
    localparam logic [7:0]  TICK_LAST   = 8'(TICK_CYCLES - 1);
    localparam int unsigned NUM_PORTS   = 5;
    typedef logic [7:0] bpc_byte_t;
    typedef logic [9:0] bpc_duty_t;
    typedef logic [NUM_PORTS-1:0][7:0] bpc_ports_t;
    // Register offsets
    localparam bpc_byte_t REG_PORT0    = 8'h00;
    localparam bpc_byte_t REG_PORT1    = 8'h01;
    localparam bpc_byte_t REG_PORT2    = 8'h02;
    localparam bpc_byte_t REG_PORT3    = 8'h03;
    localparam bpc_byte_t REG_PORT4    = 8'h04;
    localparam bpc_byte_t REG_GRP_ALL  = 8'h0a;
    localparam bpc_byte_t REG_GRP_LO   = 8'h0b;
    localparam bpc_byte_t REG_GRP_HI   = 8'h0c;
    localparam bpc_byte_t REG_PORT_IN  = 8'h0e;
    localparam bpc_byte_t REG_CFG      = 8'h10;
    localparam bpc_byte_t REG_FADE_OFF = 8'h11;
    localparam bpc_byte_t REG_FADE_ON  = 8'h12;
    localparam bpc_byte_t REG_CUR_SCL  = 8'h13;
    localparam bpc_byte_t REG_CUR_CEIL = 8'h15;
    localparam bpc_byte_t REG_DUTY_HI  = 8'h20;
    localparam bpc_byte_t REG_DUTY_LO  = 8'h21;
    localparam bpc_byte_t REG_STATUS   = 8'h22;
    // Power-on values
    localparam bpc_byte_t POR_PORT     = 8'hff;
    localparam bpc_byte_t POR_ZERO     = 8'h00;
    localparam bpc_byte_t POR_CUR_SCL  = 8'h03;
    localparam bpc_byte_t POR_CUR_CEIL = 8'h07;
    localparam bpc_byte_t POR_STATUS   = 8'h01;
    localparam bpc_byte_t DUTY_LO_MASK = 8'h03;
    // Serial address: upper five bits fixed, lower two from the strap pins
    localparam logic [4:0] I2C_ADDR_HI = 5'h1a;
    localparam logic [2:0] BIT_LAST    = 3'h7;
    // Synchroniser lanes
    localparam int SY_SCL = 0;
    localparam int SY_SDA = 1;
    localparam int SY_CLR = 2;
    localparam int SY_OVP = 3;
    localparam int SY_THM = 4;
    localparam int SY_ILM = 5;
    localparam int SY_SCH = 6;
    localparam int SY_AS0 = 7;
    localparam int SY_W   = 9;
    localparam logic [SY_W-1:0] SY_IDLE = 9'h007;

    typedef enum logic [2:0] {I2C_IDLE, I2C_ADDR, I2C_PTR, I2C_WR, I2C_RD}
        bpc_i2c_e;
    typedef struct packed {
        logic half_scale;
        logic por_on_clear;
        logic stagger;
        logic holdoff;
        logic fading_off;
        logic ramping_up;
        logic reset_run;
        logic run;
    } bpc_cfg_s;
    typedef struct packed {
        logic [2:0] rsvd;
        logic       schottky;
        logic       ilimit;
        logic       thermal;
        logic       ovp;
        logic       standby;
    } bpc_stat_s;
    typedef struct packed {
        logic [SY_W-1:0] s1, s2, s3, filt;
        bpc_i2c_e        phase;
        logic            ack_slot, rd_nack, sda_oe;
        logic [2:0]      bit_cnt;
        bpc_byte_t       shreg, tx, ptr;
        bpc_ports_t      port;
        bpc_cfg_s        cfg;
        bpc_byte_t       fade_off, fade_on, cur_scl, cur_ceil;
        bpc_byte_t       duty_hi, duty_lo;
        bpc_stat_s       stat;
        bpc_byte_t       div;
        bpc_duty_t       pwm_cnt;
        logic            boost_en;
    } bpc_state_s;

    // Load every control register with its power-on value
    function automatic bpc_state_s reg_por(input bpc_state_s s);
        bpc_state_s r;
        r = s;
        for (int i = 0; i < NUM_PORTS; i++) r.port[i] = POR_PORT;
        r.cfg      = bpc_cfg_s'(POR_ZERO);
        r.fade_off = POR_ZERO;
        r.fade_on  = POR_ZERO;
        r.cur_scl  = POR_CUR_SCL;
        r.cur_ceil = POR_CUR_CEIL;
        r.duty_hi  = POR_ZERO;
        r.duty_lo  = POR_ZERO;
        r.stat     = bpc_stat_s'(POR_STATUS);
        return r;
    endfunction : reg_por

    // Whole reset state; synchronisers start at the idle bus levels
    function automatic bpc_state_s init_state();
        bpc_state_s r;
        r      = '0;
        r.s1   = SY_IDLE;
        r.s2   = SY_IDLE;
        r.s3   = SY_IDLE;
        r.filt = SY_IDLE;
        return reg_por(r);
    endfunction : init_state
endpackage : bpc_pkg

/* verif/bpc_i2c_host.sv */
// I2C host model that programs the boost PWM block
`timescale 1ns/1ps
module bpc_i2c_host
    import bpc_pkg::*;
(
    input  wire logic       clock_in,
    input  wire logic       sda_in,
    input  wire logic [1:0] addr_sel_in,
    output logic            scl_out,
    output logic            sda_oe_out
);
    int unsigned nacks = 0;

    // Bus idles with SCL driven high and SDA released to the pull-up
    initial begin
        scl_out    = 1'b1;
        sda_oe_out = 1'b0;
    end

    // Quarter bit; each SCL phase is two quarters, 8 clocks
    task automatic q();
        repeat (4) @(negedge clock_in);
    endtask : q

    // Start or repeated start; SDA released while SCL is low, then pulled low while SCL is high
    task automatic start();
        sda_oe_out = 1'b0;
        q();
        scl_out = 1'b1;
        q();
        sda_oe_out = 1'b1;
        q();
        scl_out = 1'b0;
        q();
    endtask : start

    // One bit slot; SDA set a quarter after the fall, sampled mid-high
    task automatic slot(input logic b, output logic s);
        sda_oe_out = ~b;
        q();
        scl_out = 1'b1;
        q();
        s = sda_in;
        q();
        scl_out = 1'b0;
        q();
    endtask : slot

    // Byte out MSB first, then the acknowledge slot
    task automatic put(input bpc_byte_t d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) slot(d[i], s);
        slot(1'b1, s);
        ack = ~s;
        if (s) nacks++;
    endtask : put

    task automatic stop();
        sda_oe_out = 1'b1;
        q();
        scl_out = 1'b1;
        q();
        sda_oe_out = 1'b0;
        q();
        q();
    endtask : stop

    task automatic wr(input bpc_byte_t a, input bpc_byte_t d);
        logic k;
        start();
        put({I2C_ADDR_HI, addr_sel_in, 1'b0}, k);
        put(a, k);
        put(d, k);
        stop();
    endtask : wr

    // Pointer write, repeated start, one byte back, host NACK ends it
    task automatic rd(input bpc_byte_t a, output bpc_byte_t d);
        logic k;
        start();
        put({I2C_ADDR_HI, addr_sel_in, 1'b0}, k);
        put(a, k);
        start();
        put({I2C_ADDR_HI, addr_sel_in, 1'b1}, k);
        for (int i = 7; i >= 0; i--) slot(1'b1, d[i]);
        slot(1'b1, k);
        stop();
    endtask : rd
endmodule : bpc_i2c_host

/* verif/tb.sv */
// Self-checking bench for the boost PWM control block
`timescale 1ns/1ps
module tb;
    import bpc_pkg::*;
    logic       clock_in, nrst_in, clear_n_in, scl, host_oe, k;
    logic       sda_oe, sda_val, sda_line, standby, boost_en;
    logic [2:0] flt, busy;
    logic [1:0] addr_sel;
    bpc_ports_t port_ctrl;
    bpc_cfg_s   cfg;
    bpc_byte_t  fade_off, fade_on, cur_scl, cur_ceil, v;
    int         fails = 0;
    int         checked = 0;
    int         cyc = 0;
    localparam bpc_byte_t ROFF[14] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04,
        8'h10, 8'h11, 8'h12, 8'h13, 8'h15, 8'h20, 8'h21, 8'h22, 8'h05};
    localparam bpc_byte_t RVAL[14] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
        8'h01, 8'h00, 8'h00, 8'h03, 8'h07, 8'h00, 8'h00, 8'h01, 8'h00};

    // Open-drain data line with pull-up
    assign sda_line = ~host_oe & ~(sda_oe & ~sda_val);

    bpc_boost_ctrl uut (
        .clock_in         (clock_in),
        .nrst_in          (nrst_in),
        .scl_in           (scl),
        .sda_in           (sda_line),
        .clear_n_in       (clear_n_in),
        .addr_sel_in      (addr_sel),
        .ovp_in           (flt[0]),
        .thermal_in       (flt[1]),
        .ilimit_in        (flt[2]),
        .schottky_open_in (1'b0),
        .holdoff_in       (busy[2]),
        .fade_off_busy_in (busy[1]),
        .ramp_up_busy_in  (busy[0]),
        .sda_out          (sda_val),
        .sda_oe_out       (sda_oe),
        .port_ctrl_out    (port_ctrl),
        .cfg_out          (cfg),
        .fade_off_out     (fade_off),
        .fade_on_out      (fade_on),
        .cur_scale_out    (cur_scl),
        .cur_ceil_out     (cur_ceil),
        .standby_out      (standby),
        .boost_en_out     (boost_en)
    );

    bpc_i2c_host host (
        .clock_in    (clock_in),
        .sda_in      (sda_line),
        .addr_sel_in (addr_sel),
        .scl_out     (scl),
        .sda_oe_out  (host_oe)
    );

    initial begin
        clock_in = 1'b0;
        forever #20 clock_in = ~clock_in;
    end

    // Cycles since reset release, to time the PWM edge
    always @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) cyc <= 0;
        else cyc <= cyc + 1;
    end

    task automatic chk(input string n, input bpc_byte_t e,
                       input bpc_byte_t g);
        checked++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
            fails++;
        end
    endtask : chk

    task automatic rchk(input bpc_byte_t a, input bpc_byte_t e);
        host.rd(a, v);
        chk($sformatf("reg %h", a), e, v);
    endtask : rchk

    task automatic end_of_test();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_of_test

    // Bounded wait on the PWM output; running out ends the run
    task automatic wait_en(input logic lvl, input int lim);
        int n;
        n = 0;
        while (boost_en !== lvl && n < lim) begin
            @(negedge clock_in);
            n++;
        end
        if (n >= lim) begin
            $display("CHECK FAILED boost_en expected %b seen %b",
                     lvl, boost_en);
            fails++;
            end_of_test();
        end
    endtask : wait_en

    // Clear pin held low long enough to pass the input filter
    task automatic pulse_clear();
        clear_n_in = 1'b0;
        repeat (20) @(negedge clock_in);
        clear_n_in = 1'b1;
        repeat (20) @(negedge clock_in);
    endtask : pulse_clear

    initial begin
        {nrst_in, flt, busy} = '0;
        clear_n_in = 1'b1;
        addr_sel = 2'h2;
        repeat (10) @(negedge clock_in);
        nrst_in = 1'b1;
        @(negedge clock_in);
        for (int i = 0; i < NUM_PORTS; i++)
            chk("port_ctrl", 8'hff, port_ctrl[i]);
        chk("cfg", 8'h00, cfg);
        chk("cur_scale", 8'h03, cur_scl);
        chk("cur_ceil", 8'h07, cur_ceil);
        chk("fade_off", 8'h00, fade_off);
        chk("fade_on", 8'h00, fade_on);
        chk("standby", 8'h01, {7'h0, standby});
        $display("test power_on done");
        // Duty 66 ticks; the writes must finish before the counter gets there
        host.wr(8'h10, 8'h01);
        host.wr(8'h22, 8'h00);
        chk("boost_en", 8'h00, {7'h0, boost_en});
        host.wr(8'h21, 8'h02);
        host.wr(8'h20, 8'h10);
        wait_en(1'b1, 50);
        host.wr(8'h22, 8'h01);
        chk("boost_en", 8'h00, {7'h0, boost_en});
        host.wr(8'h22, 8'h00);
        wait_en(1'b1, 50);
        host.wr(8'h10, 8'h00);
        chk("boost_en", 8'h00, {7'h0, boost_en});
        host.wr(8'h10, 8'h01);
        wait_en(1'b1, 50);
        wait_en(1'b0, 12000);
        chk("pwm fall", 8'h01, 8'(cyc > 66 * TICK_CYCLES - 6 &&
            cyc < 66 * TICK_CYCLES + 6));
        $display("test boost_pwm done");
        host.wr(8'h10, 8'hff);
        chk("cfg_out", 8'he3, cfg);
        for (int i = 0; i < 3; i++) begin
            busy = 3'(1 << i);
            rchk(8'h10, 8'he3 | 8'(4 << i));
        end
        busy = 3'h0;
        host.wr(8'h21, 8'hff);
        rchk(8'h21, 8'h03);
        rchk(8'h20, 8'h10);
        $display("test config done");
        host.wr(8'h0a, 8'h12);
        host.wr(8'h11, 8'h5a);
        host.wr(8'h13, 8'h1c);
        host.wr(8'h10, 8'h00);
        pulse_clear();
        chk("port0", 8'h12, port_ctrl[0]);
        chk("port4", 8'h12, port_ctrl[4]);
        chk("fade_off", 8'h5a, fade_off);
        host.wr(8'h10, 8'h42);
        pulse_clear();
        for (int i = 0; i < 14; i++) rchk(ROFF[i], RVAL[i]);
        $display("test clear done");
        for (int i = 0; i < 3; i++) begin
            flt = 3'(1 << i);
            repeat (10) @(negedge clock_in);
            flt = 3'h0;
            rchk(8'h22, 8'h01 | 8'(2 << i));
            rchk(8'h22, 8'h01);
        end
        flt = 3'h4;
        rchk(8'h22, 8'h09);
        rchk(8'h22, 8'h09);
        flt = 3'h0;
        $display("test faults done");
        host.start();
        host.put({I2C_ADDR_HI, ~addr_sel, 1'b0}, k);
        host.stop();
        chk("ack", 8'h00, {7'h0, k});
        chk("nacks", 8'h01, 8'(host.nacks));
        $display("test address done");
        end_of_test();
    end
endmodule : tb
